// File: wake_pkg.sv
// Shared constants for the processing element wakeup controller
package wake_pkg;
  localparam int unsigned NUM_ELEMENTS = 4;
  localparam int unsigned NUM_AON_SRC  = 2;
  // Power-up step time and reset hold time, in nanoseconds
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned PWR_UP_TIME_NS = 400;
  localparam int unsigned RST_HOLD_NS    = 200;
  localparam int unsigned PWR_UP_CYCLES  = (PWR_UP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_HOLD_CYCLES = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  // Interrupt type codes carried with each wakeup candidate
  typedef enum logic [2:0] {
    IRQ_SHARED_DIRECT   = 3'h0,
    IRQ_SOFTWARE_GEN    = 3'h1,
    IRQ_PRIVATE_ELEMENT = 3'h2,
    IRQ_LOCALITY_MSG    = 3'h3,
    IRQ_SHARED_ROUTED   = 3'h4
  } irq_type_e;
  // Per-element power sequence
  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'h0,
    SEQ_POWER   = 3'h1,
    SEQ_RESET   = 3'h2,
    SEQ_RESTORE = 3'h3,
    SEQ_DONE    = 3'h4
  } seq_state_e;
endpackage

// File: edge_catch.sv
// Three-stage synchroniser with sticky edge capture for one wake line
module edge_catch (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RST_N,
  // Raw line and capture control
  input  wire logic raw_in,
  input  wire logic clear,
  output logic      pending,
  output logic      level
);
  logic [2:0] sync_q, sync_d;
  logic       stable_q, stable_d;
  logic       pend_q, pend_d;
  logic       rise;

  always_comb begin
    sync_d   = {sync_q[1:0], raw_in};
    stable_d = stable_q;
    // Second and third stage must agree before the level counts
    if (sync_q[1] == sync_q[2]) begin
      stable_d = sync_q[2];
    end
    rise = stable_d & ~stable_q;
    // Edge kept sticky
    // Set beats clear so an edge landing on the clear cycle survives
    pend_d = rise | (pend_q & ~clear);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync_q   <= 3'h0;
      stable_q <= 1'b0;
      pend_q   <= 1'b0;
    end else begin
      sync_q   <= sync_d;
      stable_q <= stable_d;
      pend_q   <= pend_d;
    end
  end

  assign pending = pend_q;
  assign level   = stable_q;

  a_edge_kept: assert property (@(posedge CLK) disable iff (!RST_N)
    (stable_d & ~stable_q) |=> pending)
    else $error("Captured edge not held pending");
endmodule

// File: pe_wakeup_controller.sv
// Wakeup controller bringing processing elements out of low-power states
// Operation
// - An element leaves low power on a wakeup interrupt, ignoring its mask bits and the priority.
// - Shared direct, software generated, private per-element and locality message interrupts are wakeup types.
// - Only interrupts enabled in the distributor may wake an element.
// - With the controller off, a programmable target element is woken on wakeup timer or watchdog expiry.
// - A timer or watchdog that wakes an element still raises its normal interrupt toward the controller.
// - After return from sleep or off, an interrupt naming the waking device is presented to software.
// - That interrupt is pending in the controller before restore firmware hands control back.
// - The identifying interrupt travels the ordinary device to controller path only.
// - An edge wake event is captured so it both wakes the system and is later delivered.
// - A wake powers the target element and the controller, then releases element reset before restore.
// - The controller's wake request starts power-up of the targeted element.
// - Always-on sources such as bus wake or network wake can wake elements without the controller.
// - In the deep state the wakeup timer wakes a chosen element set.
// - No message interrupts are passed to the controller while it is powered down; MSG_IRQ_PASS follows CTRL_POWERED one cycle late.
module pe_wakeup_controller #(
  parameter int unsigned N_PE  = wake_pkg::NUM_ELEMENTS,
  parameter int unsigned N_AON = wake_pkg::NUM_AON_SRC
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RST_N,
  // Interrupt candidate from the controller side
  input  wire logic             IRQ_VALID,
  input  wire logic [2:0]       IRQ_TYPE,
  input  wire logic             IRQ_ENABLED,
  input  wire logic [N_PE-1:0]  IRQ_TARGET,
  input  wire logic [N_PE-1:0]  CTRL_WAKE_REQ,
  input  wire logic             CTRL_POWERED,
  // Always-on wake sources, asynchronous
  input  wire logic             TIMER_EXPIRE,
  input  wire logic             WDOG_EXPIRE,
  input  wire logic [N_AON-1:0] AON_WAKE,
  // Target selection, static configuration
  input  wire logic [N_PE-1:0]  TIMER_TARGET,
  input  wire logic [N_PE-1:0]  WDOG_TARGET,
  input  wire logic [N_PE-1:0]  AON_TARGET,
  // Element status and handshake
  input  wire logic [N_PE-1:0]  PE_ASLEEP,
  input  wire logic [N_PE-1:0]  PE_RESTORE_DONE,
  input  wire logic             CTRL_IRQ_ACCEPT,
  // Power and reset outputs
  output logic      [N_PE-1:0]  PE_POWER_ON,
  output logic      [N_PE-1:0]  PE_RESET_N,
  output logic      [N_PE-1:0]  PE_RELEASE_OS,
  output logic                  CTRL_POWER_ON,
  // Interrupt delivery toward the controller
  output logic                  TIMER_IRQ,
  output logic                  WDOG_IRQ,
  output logic      [N_AON-1:0] AON_IRQ,
  output logic                  MSG_IRQ_PASS
);
  localparam int unsigned NSRC = 2 + N_AON;

  // Wider counts would overflow the packed vectors and the step counters
  if (N_PE < 1 || N_PE > 32 || N_AON < 1 || N_AON > 16 ||
      wake_pkg::PWR_UP_CYCLES >= (1 << wake_pkg::CNT_W) ||
      wake_pkg::RST_HOLD_CYCLES >= (1 << wake_pkg::CNT_W)) begin : g_bad_cfg
    $error("Unsupported element or source count");
  end

  localparam logic [wake_pkg::CNT_W-1:0] PWR_CNT = wake_pkg::CNT_W'(wake_pkg::PWR_UP_CYCLES);
  localparam logic [wake_pkg::CNT_W-1:0] RST_CNT = wake_pkg::CNT_W'(wake_pkg::RST_HOLD_CYCLES);

  // Source capture
  logic [NSRC-1:0] src_raw, src_pend, src_lvl, src_clr;
  assign src_raw = {AON_WAKE, WDOG_EXPIRE, TIMER_EXPIRE};

  for (genvar s = 0; s < NSRC; s++) begin : g_src
    edge_catch u_catch (
      .CLK     (CLK),
      .RST_N   (RST_N),
      .raw_in  (src_raw[s]),
      .clear   (src_clr[s]),
      .pending (src_pend[s]),
      .level   (src_lvl[s])
    );
  end

  function automatic logic [N_PE-1:0] src_target(input int unsigned s);
    if (s == 0) begin
      return TIMER_TARGET;
    end else if (s == 1) begin
      return WDOG_TARGET;
    end
    return AON_TARGET;
  endfunction

  // Wakeup interrupt qualification
  logic is_wake_type;
  logic [N_PE-1:0] irq_wake;
  always_comb begin
    unique case (wake_pkg::irq_type_e'(IRQ_TYPE))
      wake_pkg::IRQ_SHARED_DIRECT,
      wake_pkg::IRQ_SOFTWARE_GEN,
      wake_pkg::IRQ_PRIVATE_ELEMENT,
      wake_pkg::IRQ_LOCALITY_MSG: is_wake_type = 1'b1;
      default:                    is_wake_type = 1'b0;
    endcase
    irq_wake = (IRQ_VALID && IRQ_ENABLED && is_wake_type) ? IRQ_TARGET : '0;
  end

  // Per-element wake latch and power sequence
  wake_pkg::seq_state_e            st_q [N_PE];
  wake_pkg::seq_state_e            st_d [N_PE];
  logic [wake_pkg::CNT_W-1:0]      cnt_q [N_PE];
  logic [wake_pkg::CNT_W-1:0]      cnt_d [N_PE];
  logic [N_PE-1:0]                 latch_q, latch_d;
  logic [N_PE-1:0]                 req_set, seq_done;
  logic [NSRC-1:0]                 src_owed_q, src_owed_d;

  always_comb begin
    req_set = irq_wake | CTRL_WAKE_REQ;
    // Timer, watchdog and always-on lines wake with controller off
    for (int unsigned s = 0; s < NSRC; s++) begin
      if (src_pend[s]) begin
        req_set = req_set | src_target(s);
      end
    end
    req_set = req_set & PE_ASLEEP;
  end

  always_comb begin
    seq_done = '0;
    for (int unsigned p = 0; p < N_PE; p++) begin
      st_d[p]  = st_q[p];
      cnt_d[p] = cnt_q[p];
      unique case (st_q[p])
        wake_pkg::SEQ_IDLE: begin
          if (latch_q[p]) begin
            st_d[p]  = wake_pkg::SEQ_POWER;
            cnt_d[p] = PWR_CNT;
          end
        end
        wake_pkg::SEQ_POWER: begin
          if (cnt_q[p] == '0 && CTRL_POWERED) begin
            st_d[p]  = wake_pkg::SEQ_RESET;
            cnt_d[p] = RST_CNT;
          end else if (cnt_q[p] != '0) begin
            cnt_d[p] = cnt_q[p] - 1'b1;
          end
        end
        wake_pkg::SEQ_RESET: begin
          if (cnt_q[p] == '0) begin
            st_d[p] = wake_pkg::SEQ_RESTORE;
          end else begin
            cnt_d[p] = cnt_q[p] - 1'b1;
          end
        end
        wake_pkg::SEQ_RESTORE: begin
          if (PE_RESTORE_DONE[p] && (src_owed_q == '0)) begin
            st_d[p] = wake_pkg::SEQ_DONE;
          end
        end
        wake_pkg::SEQ_DONE: begin
          seq_done[p] = 1'b1;
          st_d[p]     = wake_pkg::SEQ_IDLE;
        end
        default: st_d[p] = wake_pkg::SEQ_IDLE;
      endcase
    end
    latch_d = req_set | (latch_q & ~seq_done);
  end

  // Owed deliveries: an edge has woken the system and must still reach the controller
  always_comb begin
    src_owed_d = src_owed_q;
    src_clr    = '0;
    for (int unsigned s = 0; s < NSRC; s++) begin
      if (src_pend[s] && !src_owed_q[s]) begin
        src_clr[s]    = 1'b1;
        src_owed_d[s] = 1'b1;
      end else if (src_owed_q[s] && CTRL_POWERED && CTRL_IRQ_ACCEPT) begin
        src_owed_d[s] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      latch_q    <= '0;
      src_owed_q <= '0;
      for (int unsigned p = 0; p < N_PE; p++) begin
        st_q[p]  <= wake_pkg::SEQ_IDLE;
        cnt_q[p] <= '0;
      end
    end else begin
      latch_q    <= latch_d;
      src_owed_q <= src_owed_d;
      for (int unsigned p = 0; p < N_PE; p++) begin
        st_q[p]  <= st_d[p];
        cnt_q[p] <= cnt_d[p];
      end
    end
  end

  // Registered outputs
  logic [N_PE-1:0]  pwr_d, rstn_d, rel_d;
  logic [NSRC-1:0]  irq_d;
  logic             cpwr_d, msg_d;
  logic [N_PE-1:0]  pwr_q, rstn_q, rel_q;
  logic [NSRC-1:0]  irq_q;
  logic             cpwr_q, msg_q;
  logic [N_PE-1:0]  awake_now;

  always_comb begin
    for (int unsigned p = 0; p < N_PE; p++) begin
      // Release cycle counts as awake, so power and reset do not blink before the element reports running
      awake_now[p] = !PE_ASLEEP[p] || (st_q[p] == wake_pkg::SEQ_DONE);
      pwr_d[p]     = (st_d[p] != wake_pkg::SEQ_IDLE) || awake_now[p];
      rstn_d[p]    = (st_d[p] == wake_pkg::SEQ_RESTORE) || (st_d[p] == wake_pkg::SEQ_DONE) || awake_now[p];
      rel_d[p]     = (st_d[p] == wake_pkg::SEQ_DONE);
    end
    // Controller powered with any waking element
    cpwr_d = (latch_d != '0) || (awake_now != '0);
    irq_d = src_owed_d | src_lvl;
    msg_d = CTRL_POWERED;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pwr_q  <= '0;
      rstn_q <= '0;
      rel_q  <= '0;
      irq_q  <= '0;
      cpwr_q <= 1'b0;
      msg_q  <= 1'b0;
    end else begin
      pwr_q  <= pwr_d;
      rstn_q <= rstn_d;
      rel_q  <= rel_d;
      irq_q  <= irq_d;
      cpwr_q <= cpwr_d;
      msg_q  <= msg_d;
    end
  end

  assign PE_POWER_ON   = pwr_q;
  assign PE_RESET_N    = rstn_q;
  assign PE_RELEASE_OS = rel_q;
  assign CTRL_POWER_ON = cpwr_q;
  assign TIMER_IRQ     = irq_q[0];
  assign WDOG_IRQ      = irq_q[1];
  assign AON_IRQ       = irq_q[NSRC-1:2];
  assign MSG_IRQ_PASS  = msg_q;

  // Checks
  a_irq_wakes: assert property (@(posedge CLK) disable iff (!RST_N)
    (IRQ_VALID && IRQ_ENABLED && is_wake_type && (IRQ_TARGET & PE_ASLEEP) != '0)
      |=> ((latch_q & $past(IRQ_TARGET) & $past(PE_ASLEEP)) != '0))
    else $error("Wakeup interrupt did not latch");
  a_disabled_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    (IRQ_VALID && !IRQ_ENABLED) |-> (irq_wake == '0))
    else $error("Disabled interrupt raised wake");
  a_type_filter: assert property (@(posedge CLK) disable iff (!RST_N)
    (IRQ_VALID && IRQ_TYPE == wake_pkg::IRQ_SHARED_ROUTED) |-> (irq_wake == '0))
    else $error("Routed shared interrupt woke element");
  a_timer_wakes: assert property (@(posedge CLK) disable iff (!RST_N)
    (src_pend[0] && (TIMER_TARGET & PE_ASLEEP) != '0) |=> (latch_q != '0))
    else $error("Timer expiry did not latch wake");
  a_latch_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
    ($past(latch_q[0]) && !$past(seq_done[0])) |-> latch_q[0])
    else $error("Wake latch dropped early");
  a_reset_after_pwr: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(PE_RESET_N[0]) |-> $past(PE_POWER_ON[0], 2))
    else $error("Reset released before power");
  a_release_owed: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(PE_RELEASE_OS[0]) |-> ($past(src_owed_q) == '0))
    else $error("Hand-back before interrupt pending");
  a_msg_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    !CTRL_POWERED |=> !MSG_IRQ_PASS)
    else $error("Message passed with controller off");
  a_timer_irq: assert property (@(posedge CLK) disable iff (!RST_N)
    src_owed_q[0] |-> TIMER_IRQ)
    else $error("Timer interrupt not raised");
  a_power_kept: assert property (@(posedge CLK) disable iff (!RST_N)
    PE_RELEASE_OS[0] |=> (PE_POWER_ON[0] && PE_RESET_N[0]))
    else $error("Element lost power after hand-back");
  a_release_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
    PE_RELEASE_OS[0] |=> !PE_RELEASE_OS[0])
    else $error("Hand-back pulse longer than one cycle");
  a_ctrl_on_wake: assert property (@(posedge CLK) disable iff (!RST_N)
    (latch_d != '0) |=> CTRL_POWER_ON)
    else $error("Controller not powered for a wake");

  c_irq_wake:  cover property (@(posedge CLK) disable iff (!RST_N) (irq_wake != '0));
  c_timer:     cover property (@(posedge CLK) disable iff (!RST_N) src_pend[0] && !CTRL_POWERED);
  c_aon:       cover property (@(posedge CLK) disable iff (!RST_N) src_pend[NSRC-1]);
  c_wdog:      cover property (@(posedge CLK) disable iff (!RST_N) src_pend[1]);
  c_release:   cover property (@(posedge CLK) disable iff (!RST_N) $rose(PE_RELEASE_OS[0]));
endmodule

// File: element_side_model.sv
// Model of the elements and interrupt controller facing the wakeup block
module element_side_model #(
  parameter int unsigned N_PE = 4
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Bench control
  input  wire logic [N_PE-1:0] sleep_req,
  input  wire logic [7:0]      restore_delay,
  // From the wakeup block
  input  wire logic [N_PE-1:0] power_on,
  input  wire logic [N_PE-1:0] reset_n,
  input  wire logic [N_PE-1:0] release_os,
  input  wire logic            ctrl_power_on,
  input  wire logic            irq_any,
  // Toward the wakeup block
  output logic      [N_PE-1:0] asleep,
  output logic      [N_PE-1:0] restore_done,
  output logic                 ctrl_powered,
  output logic                 irq_accept
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pwr_q;
  logic [7:0] cnt_q [N_PE];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      asleep <= '1;
      restore_done <= '0;
      ctrl_powered <= 1'b0;
      irq_accept <= 1'b0;
      pwr_q <= 3'h0;
      for (int i = 0; i < N_PE; i++) cnt_q[i] <= 8'h00;
    end else begin
      // Slow power-good so the block must wait for it
      pwr_q <= {pwr_q[1:0], ctrl_power_on};
      ctrl_powered <= pwr_q[2];
      // owed interrupts accepted only once powered
      irq_accept <= pwr_q[2] & irq_any;
      for (int i = 0; i < N_PE; i++) begin
        asleep[i] <= (asleep[i] & ~release_os[i]) | sleep_req[i];
        if (!reset_n[i] || !power_on[i]) cnt_q[i] <= 8'h00;
        else if (cnt_q[i] != 8'hff) cnt_q[i] <= cnt_q[i] + 8'h01;
        // Restore finishes only after reset release, held until handed over
        restore_done[i] <= asleep[i] & ~release_os[i] & reset_n[i] & power_on[i] & (cnt_q[i] >= restore_delay);
      end
    end
  end
endmodule

// File: pe_wakeup_controller_tb.sv
// Self-checking bench for the wakeup controller
module pe_wakeup_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NP = wake_pkg::NUM_ELEMENTS;
  localparam int unsigned NA = wake_pkg::NUM_AON_SRC;
  logic clk, rst_n, irq_valid, irq_enabled, ctrl_powered, timer_expire, wdog_expire, irq_accept;
  logic ctrl_power_on, timer_irq, wdog_irq, msg_pass;
  logic [2:0] irq_type;
  logic [NP-1:0] irq_target, ctrl_wake_req, timer_target, wdog_target, aon_target, asleep, restore_done;
  logic [NP-1:0] sleep_req, power_on, pe_reset_n, release_os;
  logic [NA-1:0] aon_wake, aon_irq;
  logic [7:0] restore_delay;
  logic [15:0] lfsr_q;
  logic [NP-1:0] expect_q [$];
  int n_mismatch, samples_checked;

  pe_wakeup_controller uut (
    .CLK(clk), .RST_N(rst_n), .IRQ_VALID(irq_valid), .IRQ_TYPE(irq_type),
    .IRQ_ENABLED(irq_enabled), .IRQ_TARGET(irq_target), .CTRL_WAKE_REQ(ctrl_wake_req),
    .CTRL_POWERED(ctrl_powered), .TIMER_EXPIRE(timer_expire), .WDOG_EXPIRE(wdog_expire),
    .AON_WAKE(aon_wake), .TIMER_TARGET(timer_target), .WDOG_TARGET(wdog_target),
    .AON_TARGET(aon_target), .PE_ASLEEP(asleep), .PE_RESTORE_DONE(restore_done),
    .CTRL_IRQ_ACCEPT(irq_accept), .PE_POWER_ON(power_on), .PE_RESET_N(pe_reset_n),
    .PE_RELEASE_OS(release_os), .CTRL_POWER_ON(ctrl_power_on), .TIMER_IRQ(timer_irq),
    .WDOG_IRQ(wdog_irq), .AON_IRQ(aon_irq), .MSG_IRQ_PASS(msg_pass)
  );

  element_side_model #(.N_PE(NP)) far (
    .clk(clk), .rst_n(rst_n), .sleep_req(sleep_req), .restore_delay(restore_delay),
    .power_on(power_on), .reset_n(pe_reset_n), .release_os(release_os),
    .ctrl_power_on(ctrl_power_on), .irq_any(timer_irq | wdog_irq | (|aon_irq)),
    .asleep(asleep), .restore_done(restore_done), .ctrl_powered(ctrl_powered), .irq_accept(irq_accept)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(string what, logic [NP-1:0] seen, logic [NP-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Scoreboard: every release pulse takes the oldest noted target
  always @(negedge clk) begin
    if (rst_n && release_os !== '0) begin
      if (expect_q.size() == 0) check("unexpected release", release_os, '0);
      else check("release target", release_os, expect_q.pop_front());
      check("msg pass at release", NP'(msg_pass), NP'(1));
      check("reset released", pe_reset_n & release_os, release_os);
      check("ctrl power at release", NP'(ctrl_power_on), NP'(1));
    end
  end

  task automatic wait_done();
    int k;
    for (k = 0; k < 400 && expect_q.size() != 0; k++) @(posedge clk);
    if (expect_q.size() != 0) begin
      n_mismatch++;
      $display("[FAIL] release expected %h seen none", expect_q[0]);
      expect_q.delete();
    end
  endtask

  // nothing targets the elements while they are put to sleep
  task automatic sleep_all();
    irq_valid <= 1'b0;
    sleep_req <= '1;
    @(posedge clk) sleep_req <= '0;
    repeat (30) @(posedge clk);
    #1 check("msg pass while off", NP'(msg_pass), NP'(ctrl_powered));
    check("ctrl power while asleep", NP'(ctrl_power_on), NP'(0));
    @(posedge clk);
  endtask

  task automatic irq_wake(logic [2:0] t, logic en, logic [NP-1:0] tgt, logic wake);
    irq_type <= t;
    irq_enabled <= en;
    irq_target <= tgt;
    irq_valid <= 1'b1;
    if (wake) expect_q.push_back(tgt);
    @(posedge clk) irq_valid <= 1'b0;
    @(posedge clk);
    #1 check("power on", power_on & tgt & asleep, wake ? tgt : '0);
    if (wake) begin
      wait_done();
      #1 check("power kept after release", power_on & pe_reset_n & tgt, tgt);
    end else begin
      repeat (19) @(posedge clk);
    end
    @(posedge clk);
  endtask

  task automatic line_wake(logic [NA+1:0] lines, logic [NP-1:0] tgt);
    expect_q.push_back(tgt);
    {aon_wake, wdog_expire, timer_expire} <= lines;
    repeat (8) @(posedge clk);
    #1 check("irq while held", NP'({aon_irq, wdog_irq, timer_irq}), NP'(lines));
    @(posedge clk) {aon_wake, wdog_expire, timer_expire} <= '0;
    wait_done();
    #1 check("irq after handover", NP'({aon_irq, wdog_irq, timer_irq}), '0);
    @(posedge clk);
  endtask

  initial begin
    {rst_n, irq_valid, irq_enabled, timer_expire, wdog_expire} = '0;
    {irq_type, irq_target, ctrl_wake_req, aon_wake, sleep_req} = '0;
    timer_target = 4'h2;
    wdog_target = 4'h4;
    aon_target = 4'h8;
    restore_delay = 8'h03;
    lfsr_q = 16'h001d;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // every wakeup type wakes a random target
    for (int t = 0; t < 4; t++) begin
      lfsr_q = lfsr_next(lfsr_q);
      restore_delay <= {3'h0, lfsr_q[7:3]};
      irq_wake(3'(t), 1'b1, NP'(1) << lfsr_q[1:0], 1'b1);
      irq_wake(3'(t), 1'b1, NP'(1) << lfsr_q[1:0], 1'b0);
      sleep_all();
      $display("wake type %0d done", t);
    end
    // routed type and disabled interrupts are refused
    irq_wake(3'h4, 1'b1, 4'h1, 1'b0);
    irq_wake(3'h0, 1'b0, 4'h1, 1'b0);
    $display("refusals done");
    // controller wake request alone powers the element
    ctrl_wake_req <= 4'h4;
    expect_q.push_back(4'h4);
    repeat (2) @(posedge clk);
    ctrl_wake_req <= '0;
    wait_done();
    sleep_all();
    $display("controller request done");
    // always-on lines wake with the controller off
    line_wake(4'h1, timer_target);
    sleep_all();
    line_wake(4'h2, wdog_target);
    sleep_all();
    line_wake(4'h4, aon_target);
    sleep_all();
    line_wake(4'h8, aon_target);
    $display("always-on wakes done");
    report_and_stop();
  end

  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    $display("[FAIL] run time expected end seen hang");
    report_and_stop();
  end
endmodule
